// ### design/ddrmr_top.sv
`timescale 1ns/1ps
module ddrmr_top
	import ddrmr_pkg::*;
#(
	parameter int INIT_COUNT = INIT_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// memory command bus
	output logic mem_cke,
	output logic mem_cs_n,
	output logic mem_ras_n,
	output logic mem_cas_n,
	output logic mem_we_n,
	output logic [2:0] mem_ba,
	output logic [15:0] mem_addr
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	generate
		if (INIT_COUNT < 1 || INIT_COUNT >= (1 << TIMER_W)) begin : g_bad
			$error("init count out of timer range");
		end
		// the gap count is loaded from an eight bit field
		if (TIMER_W < 8) begin : g_narrow
			$error("timer too narrow for load period");
		end
		if (CFG_W != $bits(ddrmr_cfg_type)) begin : g_cfg
			$error("settings word width mismatch");
		end
	endgenerate

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		ddrmr_state_type state;
		ddrmr_cfg_type cfg;
		logic [7:0] mrd;
		logic busy;
		logic done;
		logic cfg_err;
		logic start_pend;
		logic [1:0] mr_idx;
		logic [3:0] cmd;
		logic [2:0] ba;
		logic [15:0] addr;
		logic cke;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ddrmr_top_type;

	ddrmr_top_type r_reg, r_next;

	ddrmr_timer_if #(.W(TIMER_W)) tmr ();
	logic [3:0][15:0] mr_word;
	logic setup_phase;
	logic access_phase;
	logic addr_mapped;
	logic [31:0] read_value;
	logic [7:0] mrd_eff;
	ddrmr_cfg_type cfg_wr;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic cfg_ok(input ddrmr_cfg_type c);
		logic ok;
		ok = 1'b1;
		if (c.bl == BL_BAD) begin
			ok = 1'b0;
		end
		if (c.cl < CL_MIN || c.cl > CL_LIMIT) begin
			ok = 1'b0;
		end
		if (c.al == AL_BAD) begin
			ok = 1'b0;
		end
		if (c.rtt_wr == RTT_WR_BAD) begin
			ok = 1'b0;
		end
		if (c.write_latency_cycles < WL_MIN ||
			c.write_latency_cycles > WL_LIMIT) begin
			ok = 1'b0;
		end
		return ok;
	endfunction

	// ----------------------------------------
	// submodules
	// ----------------------------------------
	ddrmr_timer #(
		.W(TIMER_W),
		.RESET_COUNT(INIT_COUNT)
	) u_timer (
		.clk(pclk),
		.rstn(presetn),
		.t(tmr.timer)
	);

	ddrmr_mr_encode u_encode (
		.cfg(r_reg.cfg),
		.mr_word(mr_word)
	);

	// ----------------------------------------
	// bus decode and read mux
	// ----------------------------------------
	always_comb begin
		setup_phase = psel & ~penable;
		access_phase = psel & penable & r_reg.pready;
		cfg_wr = ddrmr_cfg_type'(pwdata[CFG_W-1:0]);
		// unmapped addresses answer with an error and read zero
		addr_mapped = (paddr == CFG_OFS) || (paddr == TIM_OFS) ||
			(paddr == CTRL_OFS) || (paddr == STAT_OFS);
		read_value = 32'h00000000;
		unique case (paddr)
			CFG_OFS: begin
				read_value[CFG_W-1:0] = r_reg.cfg;
			end
			TIM_OFS: begin
				read_value[TIM_MRD_LSB +: 8] = r_reg.mrd;
			end
			STAT_OFS: begin
				read_value[STAT_BUSY_BIT] = r_reg.busy;
				read_value[STAT_DONE_BIT] = r_reg.done;
				read_value[STAT_ERR_BIT] = r_reg.cfg_err;
				read_value[STAT_CKE_BIT] = r_reg.cke;
				read_value[STAT_STATE_LSB +: 5] = r_reg.state;
			end
			default: begin
				read_value = 32'h00000000;
			end
		endcase
		// a zero period would wrap the one-less timer load into a long gap
		mrd_eff = (r_reg.mrd < T_MRD_CYC) ? T_MRD_CYC : r_reg.mrd;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		r_next = r_reg;
		tmr.load = 1'b0;
		tmr.count = '0;
		r_next.cmd = CMD_NOP;

		// apb answer registered, zero wait states
		r_next.pready = 1'b0;
		if (setup_phase) begin
			r_next.pready = 1'b1;
			r_next.pslverr = ~addr_mapped;
			r_next.prdata = read_value;
		end
		if (access_phase && pwrite && addr_mapped) begin
			// settings locked while the memory is being loaded
			if (paddr == CFG_OFS && !r_reg.busy) begin
				if (cfg_ok(cfg_wr)) begin
					r_next.cfg = cfg_wr;
					r_next.cfg_err = 1'b0;
				end else begin
					r_next.cfg_err = 1'b1;
				end
			end
			if (paddr == TIM_OFS && !r_reg.busy) begin
				r_next.mrd = pwdata[TIM_MRD_LSB +: 8];
			end
			if (paddr == CTRL_OFS && pwdata[CTRL_START_BIT] &&
				!r_reg.busy) begin
				r_next.start_pend = 1'b1;
				r_next.busy = 1'b1;
				r_next.done = 1'b0;
			end
		end

		// sequencer
		unique case (r_reg.state)
			ST_INIT: begin
				if (tmr.expired) begin
					r_next.state = ST_IDLE;
					r_next.cke = 1'b1;
					tmr.load = 1'b1;
					tmr.count = TIMER_W'(mrd_eff - 8'h01);
				end
			end
			ST_IDLE, ST_DONE: begin
				// a start written during init waits here until the timer loaded at cke expires
				if (r_reg.start_pend && tmr.expired) begin
					r_next.start_pend = 1'b0;
					r_next.mr_idx = 2'h0;
					r_next.state = ST_GAP;
					r_next.cmd = CMD_MRS;
					r_next.ba = MR_ORDER[0];
					r_next.addr = mr_word[MR_ORDER[0][1:0]];
					tmr.load = 1'b1;
					tmr.count = TIMER_W'(mrd_eff - 8'h01);
				end
			end
			ST_GAP: begin
				// load edge is the first gap cycle, hence one less
				if (tmr.expired) begin
					if (r_reg.mr_idx == MR_LAST) begin
						r_next.state = ST_DONE;
						r_next.busy = 1'b0;
						r_next.done = 1'b1;
					end else begin
						r_next.mr_idx = r_reg.mr_idx + 2'h1;
						r_next.cmd = CMD_MRS;
						r_next.ba = MR_ORDER[r_next.mr_idx];
						r_next.addr =
							mr_word[MR_ORDER[r_next.mr_idx][1:0]];
						tmr.load = 1'b1;
						tmr.count = TIMER_W'(mrd_eff - 8'h01);
					end
				end
			end
			default: begin
				r_next.state = ST_IDLE;
				r_next.busy = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg.state <= ST_INIT;
			r_reg.cfg <= ddrmr_cfg_type'(CFG_RESET);
			r_reg.mrd <= T_MRD_CYC;
			r_reg.busy <= 1'b0;
			r_reg.done <= 1'b0;
			r_reg.cfg_err <= 1'b0;
			r_reg.start_pend <= 1'b0;
			r_reg.mr_idx <= 2'h0;
			r_reg.cmd <= CMD_NOP;
			r_reg.ba <= 3'h0;
			r_reg.addr <= 16'h0000;
			r_reg.cke <= 1'b0;
			r_reg.prdata <= 32'h00000000;
			r_reg.pready <= 1'b0;
			r_reg.pslverr <= 1'b0;
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prdata = r_reg.prdata;
	assign pready = r_reg.pready;
	assign pslverr = r_reg.pslverr;
	assign mem_cke = r_reg.cke;
	assign mem_cs_n = r_reg.cmd[3];
	assign mem_ras_n = r_reg.cmd[2];
	assign mem_cas_n = r_reg.cmd[1];
	assign mem_we_n = r_reg.cmd[0];
	assign mem_ba = r_reg.ba;
	assign mem_addr = r_reg.addr;

	// ----------------------------------------
	// mode word fields, all set in the encoder
	// ----------------------------------------
	// mr0 burst length and order, ppd, read latency, dll reset
	// mr1 dll on, nominal odt, drive, additive latency
	// mr2 write latency, dynamic odt, full array, manual, normal range

endmodule

// ### design/ddrmr_pkg.sv
package ddrmr_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int PCLK_MHZ = 25;
	localparam int PCLK_PERIOD_NS = 40;
	localparam int T_INIT_US = 500;
	localparam int INIT_CYCLES = T_INIT_US * PCLK_MHZ;
	localparam int T_MRD_NS = 39;
	localparam int T_MRD_CYC_INT =
		(T_MRD_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
	localparam logic [7:0] T_MRD_CYC =
		8'((T_MRD_CYC_INT < 1) ? 1 : T_MRD_CYC_INT);
	localparam int TIMER_W = 24;

	// ----------------------------------------
	// register map (byte offsets)
	// ----------------------------------------
	localparam logic [11:0] CFG_OFS = 12'h000;
	localparam logic [11:0] TIM_OFS = 12'h004;
	localparam logic [11:0] CTRL_OFS = 12'h008;
	localparam logic [11:0] STAT_OFS = 12'h00c;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CFG_W = 22;
	localparam int TIM_MRD_LSB = 0;
	localparam int CTRL_START_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_ERR_BIT = 2;
	localparam int STAT_CKE_BIT = 3;
	localparam int STAT_STATE_LSB = 4;

	// ----------------------------------------
	// setting encodings
	// ----------------------------------------
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_FIXED4 = 2'h2;
	localparam logic [1:0] BL_BAD = 2'h3;
	localparam logic [1:0] AL_BAD = 2'h3;
	localparam logic [1:0] RTT_WR_BAD = 2'h3;
	localparam logic [3:0] CL_MIN = 4'h5;
	localparam logic [3:0] CL_LIMIT = 4'ha;
	localparam logic [3:0] CL_BASE = 4'h4;
	localparam logic [3:0] WL_MIN = 4'h5;
	localparam logic [3:0] WL_LIMIT = 4'h8;
	localparam logic [2:0] PASR_FULL = 3'h0;
	localparam logic SR_AUTO_OFF = 1'b0;
	localparam logic SR_RANGE_NORMAL = 1'b0;
	localparam logic DLL_ON = 1'b0;

	typedef struct packed {
		logic [2:0] wr;
		logic [3:0] write_latency_cycles;
		logic [1:0] al;
		logic [3:0] cl;
		logic drive_rzq6;
		logic [1:0] rtt_wr;
		logic [1:0] rtt_nom;
		logic ppd_fast;
		logic order_il;
		logic [1:0] bl;
	} ddrmr_cfg_type;

	// wr 1, write latency 5, additive off, read latency 6, quarter odt
	localparam logic [CFG_W-1:0] CFG_RESET = 22'h0a8c10;

	// ----------------------------------------
	// command bus
	// ----------------------------------------
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [1:0] MR_LAST = 2'h3;
	localparam logic [3:0][2:0] MR_ORDER = {3'h0, 3'h1, 3'h3, 3'h2};

	typedef enum logic [4:0] {
		ST_INIT = 5'b00001,
		ST_IDLE = 5'b00010,
		ST_GAP = 5'b00100,
		ST_DONE = 5'b01000,
		ST_SPARE = 5'b10000
	} ddrmr_state_type;

endpackage

// ### design/ddrmr_timer_if.sv
`timescale 1ns/1ps
interface ddrmr_timer_if #(parameter int W = 24);
	logic load;
	logic [W-1:0] count;
	logic expired;
	modport ctrl (output load, output count, input expired);
	modport timer (input load, input count, output expired);
endinterface

// ### design/ddrmr_timer.sv
`timescale 1ns/1ps
module ddrmr_timer
	import ddrmr_pkg::*;
#(
	parameter int W = 24,
	parameter int RESET_COUNT = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// control
	ddrmr_timer_if.timer t
);
	typedef struct packed {
		logic [W-1:0] count;
	} ddrmr_tmr_type;

	ddrmr_tmr_type r_reg, r_next;

	generate
		if (W < 1 || RESET_COUNT < 0 || RESET_COUNT >= (1 << W)) begin : g_bad
			$error("reset count does not fit the counter");
		end
	endgenerate

	// ----------------------------------------
	// down counter, expired at zero
	// ----------------------------------------
	always_comb begin
		r_next = r_reg;
		if (t.load) begin
			r_next.count = t.count;
		end else if (r_reg.count != '0) begin
			r_next.count = r_reg.count - W'(1);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r_reg.count <= W'(RESET_COUNT);
		end else begin
			r_reg <= r_next;
		end
	end

	assign t.expired = (r_reg.count == '0);
endmodule

// ### design/ddrmr_mr_encode.sv
`timescale 1ns/1ps
module ddrmr_mr_encode
	import ddrmr_pkg::*;
(
	// settings
	input wire ddrmr_cfg_type cfg,
	// words indexed by mode register number
	output logic [3:0][15:0] mr_word
);
	always_comb begin
		mr_word[0] = {3'h0,
			cfg.ppd_fast,
			cfg.wr, 1'b1, 1'b0,
			3'(cfg.cl - CL_BASE),
			cfg.order_il,
			1'b0,
			cfg.bl};
		mr_word[1] = {7'h00, 1'b0, 1'b0,
			cfg.rtt_nom[1], 1'b0,
			cfg.al,
			cfg.rtt_nom[0],
			~cfg.drive_rzq6,
			DLL_ON};
		mr_word[2] = {5'h00,
			cfg.rtt_wr, 1'b0,
			SR_RANGE_NORMAL,
			SR_AUTO_OFF,
			3'(cfg.write_latency_cycles - WL_MIN),
			PASR_FULL};
		mr_word[3] = 16'h0000;
	end
endmodule

// ### verif/ddrmr_properties.sv
`timescale 1ns/1ps
module ddrmr_properties
	import ddrmr_pkg::*;
#(
	parameter int INIT_COUNT = 20
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// memory command bus
	input wire logic mem_cke,
	input wire logic mem_cs_n,
	input wire logic mem_ras_n,
	input wire logic mem_cas_n,
	input wire logic mem_we_n,
	input wire logic [2:0] mem_ba,
	input wire logic [15:0] mem_addr
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic [3:0] cmd;
	logic mrs;
	int unsigned age_reg;
	assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
	assign mrs = cmd == CMD_MRS;
	// saturates so a long run cannot wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			age_reg <= 0;
		else if (age_reg < 100000)
			age_reg <= age_reg + 1;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_mr0; mrs && mem_ba == 3'h0; endsequence
	sequence s_mr1; mrs && mem_ba == 3'h1; endsequence
	sequence s_mr2; mrs && mem_ba == 3'h2; endsequence
	sequence s_mr3; mrs && mem_ba == 3'h3; endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	chk_cmd_legal: assert property (cmd == CMD_NOP || mrs)
		else $error("command other than nop or load");
	chk_quiet_init: assert property (!mem_cke |-> cmd == CMD_NOP)
		else $error("command before clock enable");
	chk_cke_late: assert property ($rose(mem_cke) |-> age_reg > INIT_COUNT)
		else $error("clock enable too early");
	chk_order_two: assert property (s_mr2 |-> ##[1:255] s_mr3)
		else $error("mr3 did not follow mr2");
	chk_order_three: assert property (s_mr3 |-> ##[1:255] s_mr1)
		else $error("mr1 did not follow mr3");
	chk_order_one: assert property (s_mr1 |-> ##[1:255] s_mr0)
		else $error("mr0 did not follow mr1");
	chk_dll_on: assert property (s_mr1 |-> mem_addr[0] == DLL_ON)
		else $error("dll programmed off");
	chk_full_array: assert property (s_mr2 |-> mem_addr[2:0] == PASR_FULL)
		else $error("partial array programmed");
	chk_mr3_clear: assert property (s_mr3 |-> mem_addr == 16'h0000)
		else $error("mr3 word not clear");
	chk_sr_manual: assert property (s_mr2 |-> mem_addr[7:6] == 2'h0)
		else $error("self refresh options set");
	chk_wr_fields: assert property (s_mr2 |-> mem_addr[5:3] <= 3'h3 &&
		mem_addr[10:9] != 2'h3)
		else $error("bad write latency or termination");
	chk_rd_fields: assert property (s_mr0 |-> mem_addr[6:4] inside
		{[3'h1:3'h6]} && mem_addr[1:0] != 2'h3)
		else $error("bad read latency or burst");
	chk_al_field: assert property (s_mr1 |-> mem_addr[4:3] != 2'h3)
		else $error("bad additive latency");
	chk_word_hold: assert property (mrs ##1 !mrs |-> $stable(mem_addr))
		else $error("load word not held");
	chk_apb_nowait: assert property (psel && !penable |=> pready)
		else $error("apb wait state");
endmodule

bind ddrmr_top ddrmr_properties #(.INIT_COUNT(INIT_COUNT)) u_props (
	.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
	.pready, .pslverr, .mem_cke, .mem_cs_n, .mem_ras_n, .mem_cas_n,
	.mem_we_n, .mem_ba, .mem_addr
);

// ### verif/ddrmr_mem_model.sv
`timescale 1ns/1ps
module ddrmr_mem_model (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// command bus
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [2:0] ba,
	input wire logic [15:0] addr,
	// captured state
	output logic [3:0][15:0] mr,
	output logic [11:0] seq,
	output logic [7:0] gap,
	output logic [7:0] loads
);
	logic [7:0] since;
	// only four mode registers exist, so ba[2] is ignored for mr but kept in seq
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mr <= '0;
			seq <= '0;
			gap <= '0;
			loads <= '0;
			since <= '0;
		end else if (cke && {cs_n, ras_n, cas_n, we_n} == 4'h0) begin
			mr[ba[1:0]] <= addr;
			seq <= {seq[8:0], ba};
			gap <= since;
			loads <= loads + 8'h1;
			since <= 8'h1;
		end else if (since != 8'hff) begin
			since <= since + 8'h1;
		end
	end
endmodule

// ### verif/test_ddr3_mode_register_setup.sv
`timescale 1ns/1ps
module test_ddr3_mode_register_setup import ddrmr_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] mem_ba;
	logic [15:0] mem_addr;
	logic [3:0][15:0] mr;
	logic [11:0] seq;
	logic [7:0] gap, loads;
	int mismatches, tests_run, cyc, n;
	logic [7:0] tims [4] = '{8'h01, 8'h00, 8'h03, 8'hff};
	logic [21:0] bads [7] = '{22'h3, 22'h6000, 22'hc0, 22'h200, 22'h1c00,
		22'h8000, 22'h60000};
	logic [21:0] cfgs [4] = '{
		{3'h1, 4'h5, 2'h0, 4'h5, 1'h0, 2'h0, 2'h0, 1'h0, 1'h0, 2'h0},
		{3'h2, 4'h6, 2'h1, 4'ha, 1'h1, 2'h1, 2'h1, 1'h1, 1'h1, 2'h1},
		{3'h3, 4'h7, 2'h2, 4'h7, 1'h0, 2'h2, 2'h2, 1'h0, 1'h0, 2'h2},
		{3'h4, 4'h8, 2'h0, 4'h8, 1'h1, 2'h0, 2'h3, 1'h1, 1'h1, 2'h0}};

	ddrmr_top #(.INIT_COUNT(20)) dut_u (
		.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .mem_cke, .mem_cs_n, .mem_ras_n, .mem_cas_n,
		.mem_we_n, .mem_ba, .mem_addr
	);
	ddrmr_mem_model mem_u (
		.clk(pclk), .rstn(presetn), .cke(mem_cke), .cs_n(mem_cs_n),
		.ras_n(mem_ras_n), .cas_n(mem_cas_n), .we_n(mem_we_n), .ba(mem_ba),
		.addr(mem_addr), .mr, .seq, .gap, .loads
	);

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// generous for the slowest spacing run
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			report_and_stop;
		end
	end

	task report_and_stop;
		if (mismatches == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait count assumed; the bench timeout ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [15:0] exp_mr(input logic [21:0] c, input int i);
		case (i)
			0: return {3'h0, c[3], c[21:19], 2'h2, 3'(c[12:9] - 4'h4), c[2],
				1'b0, c[1:0]};
			1: return {9'h0, c[5], 1'b0, c[14:13], c[4], ~c[8], 1'b0};
			2: return {5'h0, c[7:6], 3'h0, 3'(c[18:15] - 4'h5), 3'h0};
			default: return 16'h0;
		endcase
	endfunction

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{mismatches, tests_run, cyc} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(CFG_OFS, 1'b0, 32'h0);
		check(rd, 32'h0a8c10);
		apb(TIM_OFS, 1'b0, 32'h0);
		check(rd, 32'h1);
		apb(STAT_OFS, 1'b0, 32'h0);
		check(rd, 32'h10);
		apb(12'h010, 1'b0, 32'h0);
		check({err, rd[30:0]}, 32'h80000000);
		apb(CFG_OFS, 1'b1, 32'(cfgs[0]));
		foreach (bads[i]) begin
			apb(CFG_OFS, 1'b1, 32'(cfgs[0] ^ bads[i]));
			apb(STAT_OFS, 1'b0, 32'h0);
			check(rd & 32'h4, 32'h4);
			apb(CFG_OFS, 1'b0, 32'h0);
			check(rd, 32'(cfgs[0]));
		end
		for (int k = 0; k < 4; k++) begin
			apb(CFG_OFS, 1'b1, 32'(cfgs[k]));
			apb(TIM_OFS, 1'b1, 32'(tims[k]));
			apb(CTRL_OFS, 1'b1, 32'h1);
			// both must be dropped while the sequence runs
			apb(CFG_OFS, 1'b1, 32'h0);
			// one cycle spacing ends the run before this write lands
			if (tims[k] > 8'h01)
				apb(CTRL_OFS, 1'b1, 32'h1);
			n = 0;
			do begin
				apb(STAT_OFS, 1'b0, 32'h0);
				n++;
			end while (rd[1] !== 1'b1 && n < 600);
			check(rd, 32'h8a);
			for (int i = 0; i < 4; i++)
				check(32'(mr[i]), 32'(exp_mr(cfgs[k], i)));
			check(32'(seq), 32'({3'h2, 3'h3, 3'h1, 3'h0}));
			check(32'(gap), (tims[k] == 8'h0) ? 32'h1 : 32'(tims[k]));
			check(32'(loads), 32'(4 * (k + 1)));
			apb(CFG_OFS, 1'b0, 32'h0);
			check(rd, 32'(cfgs[k]));
		end
		report_and_stop;
	end
endmodule
